// ---- shared/pgp_pkg.sv ----
// shared constants for the general port block
package pgp_pkg;
  // port width
  localparam int PGP_W = 8;

  // register byte addresses on the host bus
  localparam logic [7:0] PGP_OFS_DIR = 8'haf;
  localparam logic [7:0] PGP_OFS_LVL = 8'hcf;
  localparam logic [7:0] PGP_OFS_OUT = 8'hef;

  // reset values
  localparam logic [7:0] PGP_RST_DIR = 8'h00;
  localparam logic [7:0] PGP_RST_LVL = 8'hff;
  localparam logic [7:0] PGP_RST_OUT = 8'h00;
  // read data for an unmapped address
  localparam logic [7:0] PGP_RD_NONE = 8'h00;

  // host interface modes that use the read strobe and ready
  localparam logic [1:0] PGP_MODE0 = 2'h0;
  localparam logic [1:0] PGP_MODE1 = 2'h1;

  // pin positions of the two alternate-function pins
  localparam int PGP_BIT_INT = 6;
  localparam int PGP_BIT_WRH = 7;

  // host access sequencer
  typedef enum logic [1:0] {
    PGP_ST_IDLE,
    PGP_ST_BUSY,
    PGP_ST_DONE
  } pgp_state_t;
endpackage

// ---- logic/pgp_port.sv ----
`timescale 1ns/10ps
module pgp_port
  import pgp_pkg::*;
#(
  parameter logic [3:0] ALT_INT_MODES = 4'h3, // modes giving pin 6 to int_n
  parameter logic [3:0] ALT_WRH_MODES = 4'h2  // modes giving pin 7 to wrh_n
) (
  // clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // host interface mode, from on-chip logic
  input  wire logic [1:0]       host_mode,
  // host parallel bus pins
  input  wire logic             cs_n,
  input  wire logic             rd_n,
  input  wire logic             wr_n,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       data_in,
  output logic      [7:0]       data_out,
  output logic                  data_oe_n,
  output logic                  ready_out,
  output logic                  ready_oe_n,
  // port pins
  input  wire logic [PGP_W-1:0] pin_in,
  output logic      [PGP_W-1:0] pin_out,
  output logic      [PGP_W-1:0] pin_oe_n,
  output logic                  pullup_en,
  // alternate functions of the top pins
  input  wire logic             int_n_req,
  output logic                  wrh_n_out
);

  // two-stage synchronisers for all pin inputs
  logic             cs_n_s1_r, cs_n_s2_r;  // chip select
  logic             rd_n_s1_r, rd_n_s2_r;  // read strobe
  logic             wr_n_s1_r, wr_n_s2_r;  // write strobe
  logic [7:0]       addr_s1_r, addr_s2_r;  // address
  logic [7:0]       din_s1_r, din_s2_r;    // write data
  logic [PGP_W-1:0] pin_s1_r, pin_s2_r;    // port levels

  // first stages only feed second stages
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs_n_s1_r <= 1'b1;
      cs_n_s2_r <= 1'b1;
      rd_n_s1_r <= 1'b1;
      rd_n_s2_r <= 1'b1;
      wr_n_s1_r <= 1'b1;
      wr_n_s2_r <= 1'b1;
      addr_s1_r <= 8'h00;
      addr_s2_r <= 8'h00;
      din_s1_r  <= 8'h00;
      din_s2_r  <= 8'h00;
      pin_s1_r  <= PGP_RST_LVL;
      pin_s2_r  <= PGP_RST_LVL;
    end else if (clk_en) begin
      cs_n_s1_r <= cs_n;
      cs_n_s2_r <= cs_n_s1_r;
      rd_n_s1_r <= rd_n;
      rd_n_s2_r <= rd_n_s1_r;
      wr_n_s1_r <= wr_n;
      wr_n_s2_r <= wr_n_s1_r;
      addr_s1_r <= addr;
      addr_s2_r <= addr_s1_r;
      din_s1_r  <= data_in;
      din_s2_r  <= din_s1_r;
      pin_s1_r  <= pin_in;
      pin_s2_r  <= pin_s1_r;
    end
  end

  // decoded bus conditions
  logic bus_mode;  // mode with read strobe and ready
  logic rd_req;    // synced read request
  logic wr_req;    // synced write request
  logic alt_int;   // pin 6 taken by int_n
  logic alt_wrh;   // pin 7 taken by wrh_n

  always_comb begin
    bus_mode = (host_mode == PGP_MODE0) || (host_mode == PGP_MODE1);
    rd_req   = bus_mode && !cs_n_s2_r && !rd_n_s2_r;
    wr_req   = bus_mode && !cs_n_s2_r && !wr_n_s2_r && rd_n_s2_r;
    alt_int  = ALT_INT_MODES[host_mode];
    alt_wrh  = ALT_WRH_MODES[host_mode];
  end

  // host access sequencer state
  pgp_state_t st_r, st_nxt;
  logic       is_rd_r, is_rd_nxt;  // current cycle is a read

  // idle waits, busy does the access, done holds until strobes drop
  always_comb begin
    st_nxt    = st_r;
    is_rd_nxt = is_rd_r;
    case (st_r)
      PGP_ST_IDLE: begin
        if (rd_req || wr_req) begin
          st_nxt    = PGP_ST_BUSY;
          is_rd_nxt = rd_req;
        end
      end
      PGP_ST_BUSY: begin
        st_nxt = PGP_ST_DONE;
      end
      PGP_ST_DONE: begin
        // strobes gone: cycle over, new one may start
        if (!rd_req && !wr_req) begin
          st_nxt = PGP_ST_IDLE;
        end
      end
      default: begin
        st_nxt = PGP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r    <= PGP_ST_IDLE;
      is_rd_r <= 1'b0;
    end else if (clk_en) begin
      st_r    <= st_nxt;
      is_rd_r <= is_rd_nxt;
    end
  end

  // register file
  logic [PGP_W-1:0] dir_r, dir_nxt;  // direction config
  logic [PGP_W-1:0] out_r, out_nxt;  // output latch
  logic             pu_r, pu_nxt;    // pull-ups still on
  logic             wr_dir;          // direction write strobe
  logic             wr_out;          // latch write strobe

  // writes take effect in the busy cycle only, once per bus cycle
  always_comb begin
    wr_dir  = (st_r == PGP_ST_BUSY) && !is_rd_r && (addr_s2_r == PGP_OFS_DIR);
    wr_out  = (st_r == PGP_ST_BUSY) && !is_rd_r && (addr_s2_r == PGP_OFS_OUT);
    dir_nxt = dir_r;
    out_nxt = out_r;
    pu_nxt  = pu_r;
    if (wr_dir) begin
      dir_nxt = din_s2_r;
      pu_nxt  = 1'b0;
    end
    if (wr_out) begin
      out_nxt = din_s2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dir_r <= PGP_RST_DIR;
      out_r <= PGP_RST_OUT;
      pu_r  <= 1'b1;
    end else if (clk_en) begin
      dir_r <= dir_nxt;
      out_r <= out_nxt;
      pu_r  <= pu_nxt;
    end
  end

  // bus outputs
  logic [7:0] dout_r, dout_nxt;     // read data
  logic       doe_n_r, doe_n_nxt;   // data drive, low = driving
  logic       rdy_oe_r, rdy_oe_nxt; // ready pull-down, low = pulling

  // data latched in busy so it stays steady while driven
  always_comb begin
    dout_nxt   = dout_r;
    doe_n_nxt  = 1'b1;
    rdy_oe_nxt = 1'b1;
    if (st_r == PGP_ST_BUSY && is_rd_r) begin
      case (addr_s2_r)
        PGP_OFS_DIR: dout_nxt = dir_r;
        PGP_OFS_LVL: dout_nxt = pin_s2_r;
        PGP_OFS_OUT: dout_nxt = out_r;
        default:     dout_nxt = PGP_RD_NONE;
      endcase
    end
    // drive data only while read is held and done
    if (st_nxt == PGP_ST_DONE && is_rd_nxt && rd_req) begin
      doe_n_nxt = 1'b0;
    end
    // hold ready low from request until access is done
    if (st_nxt == PGP_ST_BUSY) begin
      rdy_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dout_r   <= PGP_RD_NONE;
      doe_n_r  <= 1'b1;
      rdy_oe_r <= 1'b1;
    end else if (clk_en) begin
      dout_r   <= dout_nxt;
      doe_n_r  <= doe_n_nxt;
      rdy_oe_r <= rdy_oe_nxt;
    end
  end

  // pin drivers, registered so every pin output is a flop
  logic [PGP_W-1:0] pdrv_r, pdrv_nxt;  // pin drive value
  logic [PGP_W-1:0] poe_r, poe_nxt;    // pin enable, low = driving
  logic             wrh_r, wrh_nxt;    // wrh_n seen on pin 7

  always_comb begin
    pdrv_nxt = out_r;
    poe_nxt  = ~dir_r;
    wrh_nxt  = 1'b1;
    // int_n leaves through pin 6 in its modes
    if (alt_int) begin
      pdrv_nxt[PGP_BIT_INT] = int_n_req;
      poe_nxt[PGP_BIT_INT]  = 1'b0;
    end
    // pin 7 becomes the wrh_n strobe input
    if (alt_wrh) begin
      poe_nxt[PGP_BIT_WRH] = 1'b1;
      wrh_nxt              = pin_s2_r[PGP_BIT_WRH];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pdrv_r <= PGP_RST_OUT;
      poe_r  <= {PGP_W{1'b1}};
      wrh_r  <= 1'b1;
    end else if (clk_en) begin
      pdrv_r <= pdrv_nxt;
      poe_r  <= poe_nxt;
      wrh_r  <= wrh_nxt;
    end
  end

  // outputs straight from flops, all but the constant ready_out
  assign data_out   = dout_r;
  assign data_oe_n  = doe_n_r;
  assign ready_out  = 1'b0; // open drain only ever pulls low
  assign ready_oe_n = rdy_oe_r;
  assign pin_out    = pdrv_r;
  assign pin_oe_n   = poe_r;
  assign pullup_en  = pu_r;
  assign wrh_n_out  = wrh_r;

  // checks
  property p_dir_in;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && !dir_r[0]) |=> pin_oe_n[0];
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("input pin driven");

  property p_dir_out;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && dir_r[1]) |=> (!pin_oe_n[1] && pin_out[1] == $past(out_r[1]));
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("output pin wrong");

  property p_dir_wr;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && wr_dir) |=> (dir_r == $past(din_s2_r));
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction not stored");

  property p_pullup;
    @(posedge sys_clk) disable iff (reset)
      $fell(pullup_en) |-> $past(wr_dir);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up dropped early");

  property p_pullup_stay;
    @(posedge sys_clk) disable iff (reset)
      !pullup_en |=> !pullup_en;
  endproperty
  a_pullup_stay: assert property (p_pullup_stay) else $error("pull-up back on");

  property p_rst_val;
    @(posedge sys_clk)
      reset |=> (dir_r == PGP_RST_DIR && out_r == PGP_RST_OUT && pin_s2_r == PGP_RST_LVL);
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");

  property p_lvl_rd;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && st_r == PGP_ST_BUSY && is_rd_r && addr_s2_r == PGP_OFS_LVL)
        |=> (data_out == $past(pin_s2_r));
  endproperty
  a_lvl_rd: assert property (p_lvl_rd) else $error("level read wrong");

  property p_out_wr;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && wr_out) |=> (out_r == $past(din_s2_r));
  endproperty
  a_out_wr: assert property (p_out_wr) else $error("latch not stored");

  property p_keep;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && !wr_out) |=> $stable(out_r);
  endproperty
  a_keep: assert property (p_keep) else $error("latch changed");

  property p_alt;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && alt_wrh) |=> pin_oe_n[PGP_BIT_WRH];
  endproperty
  a_alt: assert property (p_alt) else $error("pin 7 driven in alt mode");

  property p_drive;
    @(posedge sys_clk) disable iff (reset)
      !data_oe_n |-> (st_r == PGP_ST_DONE && is_rd_r);
  endproperty
  a_drive: assert property (p_drive) else $error("data driven outside read");

  property p_ready;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && st_r == PGP_ST_IDLE && (rd_req || wr_req))
        |=> !ready_oe_n ##1 (clk_en ? ready_oe_n : 1'b1);
  endproperty
  a_ready: assert property (p_ready) else $error("ready sequence wrong");

  c_read: cover property (@(posedge sys_clk) disable iff (reset) !data_oe_n);
  c_write: cover property (@(posedge sys_clk) disable iff (reset) wr_out);
  c_pu_off: cover property (@(posedge sys_clk) disable iff (reset) $fell(pullup_en));
endmodule

// ---- verif/pgp_host.sv ----
`timescale 1ns/10ps
// host cpu model: one strobe cycle at a time, paced by ready
module pgp_host (
  // clock
  input  wire logic       sys_clk,
  // bus pins driven by the host
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      addr,
  output logic [7:0]      data_in,
  // bus pins seen by the host
  input  wire logic [7:0] dbus,
  input  wire logic       ready
);
  // idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 8'h00;
    data_in = 8'h00;
  end

  // one bus cycle; to flags a cycle that never completed
  task automatic cyc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic to);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    cs_n = 1'b0;
    addr = a;
    data_in = d;
    rd_n = wr;
    wr_n = !wr;
    // wait states: busy first, then release of ready
    while (ready !== 1'b0 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (ready !== 1'b1 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    to = (n >= 12);
    q = dbus;
    @(posedge sys_clk);
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    // strobes high long enough for the device to go idle
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
// self-checking bench for the general port block
module testbench;
  import pgp_pkg::*;
  // clock, reset, mode
  logic       sys_clk;
  logic       reset;
  logic [1:0] host_mode;
  logic       int_n_req;
  // host bus
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [7:0] addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe_n;
  logic       ready_out;
  logic       ready_oe_n;
  logic [7:0] dbus;
  logic       ready;
  // port pins and the outside world
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic       pullup_en;
  logic       wrh_n_out;
  logic [7:0] ext;
  logic [7:0] ext_en;
  logic [7:0] pins;
  // results
  logic [7:0] q;
  logic       to;
  int         n_fail;
  int         checks;

  // open-drain ready with its pull-up; a released data bus shows garbage
  assign ready = ready_oe_n ? 1'b1 : ready_out;
  assign dbus = data_oe_n ? ~data_out : data_out;
  // pin level: device drive, else outside drive, else pull-up
  assign pins = (~pin_oe_n & pin_out)
              | (pin_oe_n & ((ext_en & ext) | (~ext_en & {8{pullup_en}})));

  pgp_port pgp_port_inst (
    .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .host_mode(host_mode),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .ready_out(ready_out),
    .ready_oe_n(ready_oe_n), .pin_in(pins), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .int_n_req(int_n_req), .wrh_n_out(wrh_n_out)
  );

  pgp_host pgp_host_inst (
    .sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .dbus(dbus), .ready(ready)
  );

  // free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // counts and verdict, then stop
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // register write; a hung cycle ends the run
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pgp_host_inst.cyc(1'b1, a, d, q, to);
    chk({7'h00, to}, 8'h00);
    if (to) begin
      finish_test;
    end
  endtask

  // register read against an expected byte
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    pgp_host_inst.cyc(1'b0, a, 8'h00, q, to);
    chk({7'h00, to}, 8'h00);
    if (to) begin
      finish_test;
    end
    chk(q, exp);
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    host_mode = PGP_MODE0;
    int_n_req = 1'b1;
    ext = 8'h00;
    ext_en = 8'h00;
    n_fail = 0;
    checks = 0;
    repeat (4) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    @(posedge sys_clk);
    #1;
    chk({7'h00, pullup_en}, 8'h01);
    chk({2'h0, pin_oe_n[5:0]}, 8'h3f);
    rd(PGP_OFS_DIR, PGP_RST_DIR);
    rd(PGP_OFS_OUT, PGP_RST_OUT);
    rd(PGP_OFS_LVL, PGP_RST_LVL);
    $display("test reset done");
    // latch written while every pin but pin 6 (driven with int_n in mode 0) is still an input
    wr(PGP_OFS_OUT, 8'ha5);
    chk({7'h00, pullup_en}, 8'h01);
    chk({2'h0, pin_oe_n[5:0]}, 8'h3f);
    rd(PGP_OFS_OUT, 8'ha5);
    wr(PGP_OFS_DIR, 8'h0f);
    chk({7'h00, pullup_en}, 8'h00);
    chk({2'h0, pin_oe_n[5:0]}, 8'h30);
    chk({4'h0, pin_out[3:0]}, 8'h05);
    $display("test direction done");
    // mixed inputs and outputs seen through the level register
    ext_en = 8'hb0;
    ext = 8'h20;
    int_n_req = 1'b0;
    rd(PGP_OFS_LVL, 8'h25);
    chk({6'h00, pin_oe_n[6], pin_out[6]}, 8'h00);
    wr(PGP_OFS_LVL, 8'h00);
    rd(PGP_OFS_LVL, 8'h25);
    rd(PGP_OFS_DIR, 8'h0f);
    rd(8'h00, PGP_RD_NONE);
    $display("test levels done");
    // mode 1 hands pin 7 to the upper write strobe
    chk({7'h00, wrh_n_out}, 8'h01);
    host_mode = PGP_MODE1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk({7'h00, wrh_n_out}, 8'h00);
    // pin 7 pulled high from outside: the strobe copy must follow it
    ext = 8'ha0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk({7'h00, wrh_n_out}, 8'h01);
    rd(PGP_OFS_OUT, 8'ha5);
    $display("test mode 1 done");
    // other modes: no ready, bus left alone
    host_mode = 2'h2;
    pgp_host_inst.cyc(1'b0, PGP_OFS_OUT, 8'h00, q, to);
    chk({7'h00, to}, 8'h01);
    // undriven bus shows the inverse of the last byte read (a5)
    chk(q, 8'h5a);
    chk({7'h00, data_oe_n}, 8'h01);
    $display("test refused mode done");
    finish_test;
  end
endmodule
